/* File: logic/gofs_defs.svh */
// Constants of the global and overcurrent status register bank
`ifndef GOFS_DEFS_SVH
`define GOFS_DEFS_SVH

// ****************************************************************
// Address byte fields (bit 7 op, bits 6:2 register, bit 1 label)
// ****************************************************************
`define GOFS_ADDR_W 5
`define GOFS_ADDR_GLOBAL 5'h06
`define GOFS_ADDR_OC_1_4 5'h16
`define GOFS_ADDR_OC_5_8 5'h0E

// ****************************************************************
// Global status bit positions, reset value, switch count and sync stages
// ****************************************************************
`define GOFS_BIT_PROTO_ERR 7
`define GOFS_BIT_LOAD_FAULT 6
`define GOFS_BIT_UNDERVOLT 5
`define GOFS_BIT_OVERVOLT 4
`define GOFS_BIT_NO_POR 3
`define GOFS_BIT_THERM_SD 2
`define GOFS_BIT_THERM_PW 1
`define GOFS_BIT_RESERVED 0
`define GOFS_STATUS_RESET 8'h00
`define GOFS_SWITCH_COUNT 16
`define GOFS_SYNC_STAGES 3

`endif

/* File: logic/gofs_pkg.sv */
// Types of the global and overcurrent status register bank
package gofs_pkg;

  // One-hot register select decoded from the address field
  typedef enum logic [3:0] {
    GOFS_SEL_NONE = 4'h1,
    GOFS_SEL_GLOBAL = 4'h2,
    GOFS_SEL_OC_1_4 = 4'h4,
    GOFS_SEL_OC_5_8 = 4'h8
  } gofs_sel_e;

  typedef logic [7:0] gofs_byte_t;

endpackage

/* File: logic/gofs_status.sv */
// Global status and overcurrent status register bank of the half-bridge driver
//
// Operation
// - Protocol error from serial logic sets bit 7 until cleared.
// - Bit 6 is read-only OR of all overcurrent and open-load flags.
// - Bit 6 drops to zero by itself once all those flags clear.
// - Undervoltage latches bit 5 and disables all power outputs.
// - Overvoltage latches bit 4 and disables all power outputs.
// - Bit 3 reads zero after power-on reset, one when none occurred since.
// - Thermal shutdown latches bit 2 and disables all power outputs.
// - Thermal pre-warning sets bit 1; outputs stay enabled.
// - Bit 0 is reserved and always reads zero.
// - Overcurrent on one switch latches its flag and disables only that switch.
// - First overcurrent register: bridges 1-4, low-side below high-side.
// - Second overcurrent register: bridges 5-8, same order.
// - Each overcurrent flag reads zero until an overcurrent sets it.
// - Latched flags (bits 7, 5, 4, 2, 1 and overcurrent) never clear by themselves, only by a clear command.
// - Every status register reads all zeros after reset, except bit 6 while an open-load flag is present.
`timescale 1ns/1ps
`include "gofs_defs.svh"

module gofs_status #(
  parameter int unsigned SWITCHES = `GOFS_SWITCH_COUNT,
  parameter int unsigned EXT_FLAGS = 20
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic access_strobe_in,
  input wire logic access_clear_in,
  input wire logic [`GOFS_ADDR_W-1:0] access_addr_in,
  input wire logic protocol_error_in,
  input wire logic supply_undervoltage_in,
  input wire logic supply_overvoltage_in,
  input wire logic thermal_shutdown_in,
  input wire logic thermal_prewarning_in,
  input wire logic [SWITCHES-1:0] switch_overcurrent_in,
  input wire logic [EXT_FLAGS-1:0] other_load_flags_in,
  output logic [7:0] read_data_out,
  output logic read_valid_out,
  output logic all_outputs_disable_out,
  output logic [SWITCHES-1:0] switch_disable_out
);

  // ****************************************************************
  // Register address decode
  // ****************************************************************

  // Shared by the read mux and the clear logic
  function automatic gofs_pkg::gofs_sel_e decode_sel(input logic [`GOFS_ADDR_W-1:0] addr);
    case (addr)
      `GOFS_ADDR_GLOBAL: decode_sel = gofs_pkg::GOFS_SEL_GLOBAL;
      `GOFS_ADDR_OC_1_4: decode_sel = gofs_pkg::GOFS_SEL_OC_1_4;
      `GOFS_ADDR_OC_5_8: decode_sel = gofs_pkg::GOFS_SEL_OC_5_8;
      default: decode_sel = gofs_pkg::GOFS_SEL_NONE;
    endcase
  endfunction

  localparam int unsigned FAULTS = SWITCHES + 4;

  gofs_pkg::gofs_sel_e sel;
  logic clear_global;
  logic clear_oc_lo;
  logic clear_oc_hi;

  // Clear strobes, one per byte-wide register
  always_comb begin
    sel = decode_sel(access_addr_in);
    clear_global = 1'b0;
    clear_oc_lo = 1'b0;
    clear_oc_hi = 1'b0;
    if (access_strobe_in && access_clear_in) begin
      case (sel)
        gofs_pkg::GOFS_SEL_GLOBAL: clear_global = 1'b1;
        gofs_pkg::GOFS_SEL_OC_1_4: clear_oc_lo = 1'b1;
        gofs_pkg::GOFS_SEL_OC_5_8: clear_oc_hi = 1'b1;
        default: clear_global = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Analog fault input synchronisers
  // ****************************************************************

  logic [FAULTS-1:0] fault_raw;
  logic [FAULTS-1:0] sync1_reg;
  logic [FAULTS-1:0] sync2_reg;
  logic [FAULTS-1:0] sync3_reg;
  logic [FAULTS-1:0] fault_filt_reg;

  assign fault_raw = {switch_overcurrent_in, thermal_prewarning_in, thermal_shutdown_in,
                      supply_overvoltage_in, supply_undervoltage_in};

  // Comparator flags are asynchronous; stage 1 feeds only stage 2
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= fault_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // A level counts once the last two stages agree, filtering one-cycle glitches
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fault_filt_reg <= '0;
    end else begin
      for (int i = 0; i < FAULTS; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          fault_filt_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  logic uv_seen;
  logic ov_seen;
  logic tsd_seen;
  logic tpw_seen;
  logic [SWITCHES-1:0] oc_seen;

  assign uv_seen = fault_filt_reg[0];
  assign ov_seen = fault_filt_reg[1];
  assign tsd_seen = fault_filt_reg[2];
  assign tpw_seen = fault_filt_reg[3];
  assign oc_seen = fault_filt_reg[FAULTS-1:4];

  // ****************************************************************
  // Global status flags
  // ****************************************************************

  logic proto_err_reg;
  logic undervolt_reg;
  logic overvolt_reg;
  logic no_por_reg;
  logic therm_sd_reg;
  logic therm_pw_reg;

  // Set wins over clear so an event in the clear cycle is kept
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      proto_err_reg <= 1'b0;
      undervolt_reg <= 1'b0;
      overvolt_reg <= 1'b0;
      therm_sd_reg <= 1'b0;
      therm_pw_reg <= 1'b0;
    end else begin
      proto_err_reg <= protocol_error_in | (proto_err_reg & ~clear_global);
      undervolt_reg <= uv_seen | (undervolt_reg & ~clear_global);
      overvolt_reg <= ov_seen | (overvolt_reg & ~clear_global);
      therm_sd_reg <= tsd_seen | (therm_sd_reg & ~clear_global);
      therm_pw_reg <= tpw_seen | (therm_pw_reg & ~clear_global);
    end
  end

  // Zero marks a power-on reset; the clear command acknowledges it
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      no_por_reg <= 1'b0;
    end else if (clear_global) begin
      no_por_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Per-switch overcurrent flags
  // ****************************************************************

  // Index 2n is low-side, 2n+1 high-side of bridge n+1
  logic [SWITCHES-1:0] oc_reg;
  logic [SWITCHES-1:0] oc_clear;

  assign oc_clear = {{(SWITCHES/2){clear_oc_hi}}, {(SWITCHES/2){clear_oc_lo}}};

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      oc_reg <= '0;
    end else begin
      oc_reg <= oc_seen | (oc_reg & ~oc_clear);
    end
  end

  // ****************************************************************
  // Output shutdown
  // ****************************************************************

  // Driven from latched flags so a switch stays off until software clears
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      all_outputs_disable_out <= 1'b0;
      switch_disable_out <= '0;
    end else begin
      all_outputs_disable_out <= undervolt_reg | overvolt_reg | therm_sd_reg;
      switch_disable_out <= oc_reg;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************

  // Summary is combinational, so it falls as soon as the last flag clears
  logic load_fault;
  assign load_fault = (|oc_reg) | (|other_load_flags_in);

  gofs_pkg::gofs_byte_t global_byte;

  always_comb begin
    global_byte = `GOFS_STATUS_RESET;
    global_byte[`GOFS_BIT_PROTO_ERR] = proto_err_reg;
    global_byte[`GOFS_BIT_LOAD_FAULT] = load_fault;
    global_byte[`GOFS_BIT_UNDERVOLT] = undervolt_reg;
    global_byte[`GOFS_BIT_OVERVOLT] = overvolt_reg;
    global_byte[`GOFS_BIT_NO_POR] = no_por_reg;
    global_byte[`GOFS_BIT_THERM_SD] = therm_sd_reg;
    global_byte[`GOFS_BIT_THERM_PW] = therm_pw_reg;
    global_byte[`GOFS_BIT_RESERVED] = 1'b0;
  end

  // Clear access returns the content held before the clear
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      read_data_out <= `GOFS_STATUS_RESET;
      read_valid_out <= 1'b0;
    end else begin
      read_valid_out <= access_strobe_in;
      if (access_strobe_in) begin
        case (sel)
          gofs_pkg::GOFS_SEL_GLOBAL: read_data_out <= global_byte;
          gofs_pkg::GOFS_SEL_OC_1_4: read_data_out <= oc_reg[7:0];
          gofs_pkg::GOFS_SEL_OC_5_8: read_data_out <= oc_reg[15:8];
          default: read_data_out <= `GOFS_STATUS_RESET;
        endcase
      end
    end
  end

endmodule // gofs_status

/* File: tb/gofs_status_assertions.sv */
// Port checker for the status register bank
`timescale 1ns/1ps
module gofs_status_chk #(
  parameter int unsigned SWITCHES = 16
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic access_strobe_in,
  input wire logic access_clear_in,
  input wire logic [4:0] access_addr_in,
  input wire logic [7:0] read_data_out,
  input wire logic read_valid_out,
  input wire logic all_outputs_disable_out,
  input wire logic [SWITCHES-1:0] switch_disable_out
);
  // One clock; nothing judged in reset
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Address of the access being answered
  logic [4:0] addr_q;
  logic glob_rd;
  always_ff @(posedge clock_in) addr_q <= access_addr_in;
  assign glob_rd = read_valid_out && addr_q == 5'h06;
  chk_answer_next: assert property (
    access_strobe_in |=> read_valid_out) else $error("answer missing");
  chk_answer_cause: assert property (
    read_valid_out |-> $past(access_strobe_in)) else $error("answer without access");
  chk_reserved_zero: assert property (
    glob_rd |-> !read_data_out[0]) else $error("reserved bit set");
  chk_global_off: assert property (
    glob_rd |-> all_outputs_disable_out == |(read_data_out & 8'h34)) else $error("shutoff");
  chk_load_sum: assert property (
    glob_rd && |switch_disable_out |-> read_data_out[6]) else $error("load summary");
  chk_map_low: assert property (
    read_valid_out && addr_q == 5'h16 |-> read_data_out == switch_disable_out[7:0])
    else $error("low map");
  chk_map_high: assert property (
    read_valid_out && addr_q == 5'h0E |-> read_data_out == switch_disable_out[15:8])
    else $error("high map");
  // A latched shutoff only drops after a clear of the global register
  chk_off_sticky: assert property (
    $fell(all_outputs_disable_out) |->
    $past(access_strobe_in && access_clear_in && access_addr_in == 5'h06, 2))
    else $error("shutoff dropped");
endmodule // gofs_status_chk
bind gofs_status gofs_status_chk #(.SWITCHES(SWITCHES)) u_chk (.clock_in, .resetn_in,
  .access_strobe_in, .access_clear_in, .access_addr_in, .read_data_out, .read_valid_out,
  .all_outputs_disable_out, .switch_disable_out);

/* File: tb/gofs_host_model.sv */
// Host model issuing status accesses
`timescale 1ns/1ps
module gofs_host_model (
  input wire logic clock_in,
  input wire logic [7:0] read_data_in,
  input wire logic read_valid_in,
  output logic access_strobe_out,
  output logic access_clear_out,
  output logic [4:0] access_addr_out
);
  // Idle until the first access
  initial begin
    access_strobe_out = 1'b0;
    access_clear_out = 1'b0;
    access_addr_out = 5'h00;
  end
  // One byte per access, input c chooses clear
  task automatic access(input logic c, input logic [4:0] a, output logic [7:0] d,
                        output logic v);
    @(posedge clock_in);
    access_strobe_out <= 1'b1;
    access_clear_out <= c;
    access_addr_out <= a;
    @(posedge clock_in);
    access_strobe_out <= 1'b0;
    // Released lines flip so stale values never match
    access_clear_out <= ~c;
    access_addr_out <= ~a;
    // Answer stands in the cycle after the taking edge; sample it at the next edge
    @(posedge clock_in);
    v = read_valid_in;
    d = read_data_in;
  endtask
endmodule // gofs_host_model

/* File: tb/gofs_status_bench.sv */
// Self-checking bench for the status register bank
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("mismatch %0t %h %h", $time, (a), (e)); end end
module gofs_status_bench;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic proto = 1'b0;
  logic [3:0] flt = 4'h0;
  logic [15:0] oc = 16'h0000;
  logic [19:0] ext = 20'h00000;
  logic stb, clr, rvalid, all_off;
  logic [4:0] adr;
  logic [7:0] rdata;
  logic [15:0] sw_off;
  int num_errors = 0;
  int n_checks = 0;
  // 250 MHz logic clock
  always #2 clock_in = ~clock_in;
  gofs_host_model u_host (.clock_in, .read_data_in(rdata), .read_valid_in(rvalid),
    .access_strobe_out(stb), .access_clear_out(clr), .access_addr_out(adr));
  gofs_status DUT (.clock_in, .resetn_in, .access_strobe_in(stb), .access_clear_in(clr),
    .access_addr_in(adr), .protocol_error_in(proto), .supply_undervoltage_in(flt[3]),
    .supply_overvoltage_in(flt[2]), .thermal_shutdown_in(flt[1]),
    .thermal_prewarning_in(flt[0]), .switch_overcurrent_in(oc),
    .other_load_flags_in(ext), .read_data_out(rdata), .read_valid_out(rvalid),
    .all_outputs_disable_out(all_off), .switch_disable_out(sw_off));
  // One access, returned byte compared
  task automatic acc(input logic c, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_host.access(c, a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence; fault levels held 8 cycles to pass the filter
  initial begin
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    acc(1'b0, 5'h06, 8'h00);
    acc(1'b0, 5'h16, 8'h00);
    acc(1'b0, 5'h0E, 8'h00);
    acc(1'b1, 5'h1F, 8'h00);
    @(posedge clock_in);
    flt <= 4'h1;
    repeat (8) @(posedge clock_in);
    `CHK(all_off, 1'b0)
    flt <= 4'hF;
    proto <= 1'b1;
    repeat (8) @(posedge clock_in);
    flt <= 4'h0;
    proto <= 1'b0;
    repeat (8) @(posedge clock_in);
    `CHK(all_off, 1'b1)
    acc(1'b1, 5'h06, 8'hB6);
    acc(1'b0, 5'h06, 8'h08);
    `CHK(all_off, 1'b0)
    // Faults at the far ends of both overcurrent registers
    @(posedge clock_in);
    oc <= 16'h8001;
    repeat (8) @(posedge clock_in);
    oc <= 16'h0000;
    repeat (8) @(posedge clock_in);
    `CHK(sw_off, 16'h8001)
    `CHK(all_off, 1'b0)
    acc(1'b0, 5'h06, 8'h48);
    acc(1'b1, 5'h16, 8'h01);
    acc(1'b0, 5'h06, 8'h48);
    acc(1'b1, 5'h0E, 8'h80);
    acc(1'b0, 5'h06, 8'h08);
    acc(1'b0, 5'h16, 8'h00);
    `CHK(sw_off, 16'h0000)
    // Outside open-load flag, and a pre-warning still present through a clear
    @(posedge clock_in);
    ext <= 20'h80000;
    flt <= 4'h1;
    repeat (8) @(posedge clock_in);
    acc(1'b1, 5'h06, 8'h4A);
    acc(1'b0, 5'h06, 8'h4A);
    @(posedge clock_in);
    ext <= 20'h00000;
    flt <= 4'h0;
    repeat (8) @(posedge clock_in);
    acc(1'b1, 5'h06, 8'h0A);
    acc(1'b0, 5'h06, 8'h08);
    `CHK(all_off, 1'b0)
    // Mid-run reset: the power-on marker must read zero again
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    acc(1'b0, 5'h06, 8'h00);
    finish_test();
  end
endmodule // gofs_status_bench
